// ---- core/fzr_pkg.sv ----
package fzr_pkg;

  // ***********************************************************
  // Data path and depth
  // ***********************************************************
  localparam int DATA_W       = 18;
  localparam int BASE_DEPTH   = 512;
  localparam int FIRST_WORD_FALL_THROUGH_EXTRA   = 1;
  localparam int SETUP_MARGIN = 2;
  localparam int MIN_XFER     = 2;

  // ***********************************************************
  // Reset values and timing
  // ***********************************************************
  localparam int                RESET_CYCLES = 4;
  localparam logic [DATA_W-1:0] DOUT_RESET   = 18'h00000;

endpackage

// ---- core/fzr_if.sv ----
`timescale 1ns/1ps
interface fzr_if import fzr_pkg::*; ();

  logic              master_reset_n;
  logic              partial_reset_n;
  logic              retransmit_style_select;
  logic              first_word_fall_through;
  logic              wide_port;
  logic              wr_en;
  logic [DATA_W-1:0] wr_data;
  logic              rd_en;
  logic              output_enable_n;
  logic              retransmit_request;
  logic              full_indicator_n;
  logic              input_space_available_n;
  logic              empty_indicator_n;
  logic              out_word_valid_n;
  logic [DATA_W-1:0] read_data_out;
  logic              read_data_oe;
  wire  [DATA_W-1:0] read_data_bus;

  // Disabled outputs read as the reset word; no floating value inside the core
  assign read_data_bus = read_data_oe ? read_data_out : DOUT_RESET;

  modport device (
    input  master_reset_n,
    input  partial_reset_n,
    input  retransmit_style_select,
    input  first_word_fall_through,
    input  wide_port,
    input  wr_en,
    input  wr_data,
    input  rd_en,
    input  output_enable_n,
    input  retransmit_request,
    output full_indicator_n,
    output input_space_available_n,
    output empty_indicator_n,
    output out_word_valid_n,
    output read_data_out,
    output read_data_oe
  );

  modport host (
    output master_reset_n,
    output partial_reset_n,
    output retransmit_style_select,
    output first_word_fall_through,
    output wide_port,
    output wr_en,
    output wr_data,
    output rd_en,
    output output_enable_n,
    output retransmit_request,
    input  full_indicator_n,
    input  input_space_available_n,
    input  empty_indicator_n,
    input  out_word_valid_n,
    input  read_data_bus
  );

endinterface

// ---- core/fzr_device.sv ----
// Functional notes
// R1 - Standard empty retransmit: flag updates, data shown
// R2 - Reader holds output enable low for data
// R3 - Standard: at most depth-2 words before setup
// R4 - Standard depth: base if wide, else double
// R5 - Fall-through depth is standard depth plus one
// R6 - Standard: two writes, two reads before retransmit
// R7 - Style select held low during master reset
// R8 - Fall-through empty retransmit: valid flag, data shown
// R9 - Fall-through: at most depth-2 words before setup
// R10 - Fall-through: two writes before retransmit
// R11 - Retransmit rewinds read pointer, write pointer kept
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
module fzr_device import fzr_pkg::*; #(
  parameter int BASE = BASE_DEPTH
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  fzr_if.device                       lnk,
  output logic [$clog2(2*BASE):0]     level_q
);

  // ***********************************************************
  // Sizing
  // ***********************************************************
  localparam int MEM_D = 2 * BASE;
  localparam int AW    = $clog2(MEM_D);
  localparam int CW    = AW + 1;

  generate
    if (BASE < 4 || (BASE & (BASE - 1)) != 0) begin : g_bad_base
      $error("BASE must be a power of two, at least 4");
    end
  endgenerate

  logic [DATA_W-1:0] mem [MEM_D];

  logic          first_word_fall_through_q;
  logic          wide_q;
  logic          style_q;
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW-1:0] rd_ptr_d;
  logic [CW-1:0] occ_q;
  logic [CW-1:0] occ_d;
  logic [CW-1:0] wr_total_q;
  logic          out_valid_q;
  logic          out_valid_d;
  logic [DATA_W-1:0] dout_q;
  logic          empty_n_q;
  logic          full_n_q;
  logic          ir_n_q;
  logic          or_n_q;
  logic          oe_q;

  logic          clear;
  logic [CW-1:0] depth_eff;
  logic [CW-1:0] mem_words;
  logic          wr_ok;
  logic          std_rd;
  logic          fw_pop;
  logic          fw_load;
  logic          rt_zero;
  logic          rt_slow;
  logic          take;

  // ***********************************************************
  // Mode capture during master reset
  // ***********************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      first_word_fall_through_q  <= 1'b0;
      wide_q  <= 1'b1;
      style_q <= 1'b0;
    end else if (!lnk.master_reset_n) begin
      first_word_fall_through_q  <= lnk.first_word_fall_through;
      wide_q  <= lnk.wide_port;
      style_q <= lnk.retransmit_style_select;  // see R7
    end
  end

  // ***********************************************************
  // Decode
  // ***********************************************************
  assign clear = !lnk.master_reset_n || !lnk.partial_reset_n;

  // Depth grows by one in fall-through for the output stage
  assign depth_eff = (wide_q ? CW'(BASE) : CW'(MEM_D))    // see R4
                   + (first_word_fall_through_q ? CW'(FIRST_WORD_FALL_THROUGH_EXTRA) : CW'(0)); // see R5

  assign mem_words = occ_q - ((first_word_fall_through_q && out_valid_q) ? CW'(1) : CW'(0));
  // Full blocks writes so that the limit before setup keeps full clear
  assign wr_ok     = lnk.wr_en && (occ_q != depth_eff);   // see R3
  assign rt_zero   = lnk.retransmit_request && !style_q && (wr_total_q != '0);
  assign rt_slow   = lnk.retransmit_request && style_q;
  assign std_rd    = !first_word_fall_through_q && lnk.rd_en && (occ_q != '0) && !lnk.retransmit_request;
  assign fw_pop    = first_word_fall_through_q && lnk.rd_en && out_valid_q;
  assign fw_load   = first_word_fall_through_q && (mem_words != '0) && (!out_valid_q || lnk.rd_en)
                   && !lnk.retransmit_request;
  assign take      = std_rd || fw_load;

  // ***********************************************************
  // Next occupancy and read pointer
  // ***********************************************************
  always_comb begin
    occ_d       = occ_q;
    rd_ptr_d    = rd_ptr_q;
    out_valid_d = out_valid_q;
    if (clear) begin
      occ_d       = '0;
      rd_ptr_d    = '0;
      out_valid_d = 1'b0;
    end else if (rt_zero) begin
      // Replay from the first stored word; write side left alone
      rd_ptr_d    = AW'(1);                               // see R11
      out_valid_d = first_word_fall_through_q;
      occ_d       = wr_total_q + (wr_ok ? CW'(1) : CW'(0))
                  - (first_word_fall_through_q ? CW'(0) : CW'(1));
    end else if (rt_slow) begin
      rd_ptr_d    = '0;
      out_valid_d = 1'b0;
      occ_d       = wr_total_q + (wr_ok ? CW'(1) : CW'(0));
    end else begin
      if (take) begin
        rd_ptr_d = rd_ptr_q + AW'(1);
      end
      if (fw_load) begin
        out_valid_d = 1'b1;
      end else if (fw_pop) begin
        out_valid_d = 1'b0;
      end
      occ_d = occ_q + (wr_ok ? CW'(1) : CW'(0))
            - ((std_rd || fw_pop) ? CW'(1) : CW'(0));
    end
  end

  // ***********************************************************
  // Storage and write side
  // ***********************************************************
  always_ff @(posedge clk) begin
    if (wr_ok && !clear) begin
      mem[wr_ptr_q] <= lnk.wr_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_q   <= '0;
      wr_total_q <= '0;
    end else if (clear) begin
      wr_ptr_q   <= '0;
      wr_total_q <= '0;
    end else if (wr_ok) begin
      wr_ptr_q <= wr_ptr_q + AW'(1);
      // Saturates; a replay is only meaningful before the pointer wraps
      if (wr_total_q != CW'(MEM_D)) begin
        wr_total_q <= wr_total_q + CW'(1);
      end
    end
  end

  // ***********************************************************
  // Read side state
  // ***********************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_ptr_q    <= '0;
      occ_q       <= '0;
      out_valid_q <= 1'b0;
    end else begin
      rd_ptr_q    <= rd_ptr_d;
      occ_q       <= occ_d;
      out_valid_q <= out_valid_d;
    end
  end

  // First word loaded on the edge that takes the retransmit, no added latency
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dout_q <= DOUT_RESET;
    end else if (clear) begin
      dout_q <= DOUT_RESET;
    end else if (rt_zero) begin
      dout_q <= mem[0];                                   // see R1, R8, R11
    end else if (take) begin
      dout_q <= mem[rd_ptr_q];
    end
  end

  // ***********************************************************
  // Flags, taken from next state so they track the same edge
  // ***********************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      empty_n_q <= 1'b0;
      full_n_q  <= 1'b1;
      ir_n_q    <= 1'b0;
      or_n_q    <= 1'b1;
      level_q   <= '0;
    end else begin
      empty_n_q <= (occ_d != '0);                         // see R1
      full_n_q  <= (occ_d != depth_eff);                  // see R3
      ir_n_q    <= (occ_d == depth_eff);                  // see R9
      or_n_q    <= first_word_fall_through_q ? !out_valid_d : (occ_d == '0); // see R8
      level_q   <= occ_d;
    end
  end

  // Enable is registered so the output pins come from a flip-flop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= !lnk.output_enable_n;                       // see R2
    end
  end

  assign lnk.full_indicator_n        = full_n_q;
  assign lnk.input_space_available_n = ir_n_q;
  assign lnk.empty_indicator_n       = empty_n_q;
  assign lnk.out_word_valid_n        = or_n_q;
  assign lnk.read_data_out           = dout_q;
  assign lnk.read_data_oe            = oe_q;

endmodule

// ---- core/fzr_host.sv ----
`timescale 1ns/1ps
module fzr_host import fzr_pkg::*; #(
  parameter int BASE  = BASE_DEPTH,
  parameter int RST_C = RESET_CYCLES
) (
  input  wire logic              clk,
  input  wire logic              rst,
  fzr_if.host                    lnk,
  input  wire logic              user_master_reset,
  input  wire logic              user_partial_reset,
  input  wire logic              user_first_word_fall_through,
  input  wire logic              user_wide,
  input  wire logic              user_write,
  input  wire logic [DATA_W-1:0] user_wdata,
  input  wire logic              user_read,
  input  wire logic              user_retransmit,
  output logic [DATA_W-1:0]      user_rdata_q,
  output logic                   user_rvalid_q,
  output logic                   user_refused_q,
  output logic                   user_busy_q
);

  localparam int CW = $clog2(2 * BASE) + 2;
  localparam int RW = $clog2(RST_C + 1);

  generate
    if (RST_C < 1 || BASE < 4) begin : g_bad_param
      $error("RST_C must be at least 1 and BASE at least 4");
    end
  endgenerate

  logic [RW-1:0]     mrs_cnt_q;
  logic              mrs_n_q;
  logic              prs_n_q;
  logic              first_word_fall_through_q;
  logic              wide_q;
  logic              wr_en_q;
  logic [DATA_W-1:0] wr_data_q;
  logic              rd_en_q;
  logic              rt_q;
  logic              oe_n_q;
  logic [CW-1:0]     wr_cnt_q;
  logic [CW-1:0]     rd_cnt_q;
  logic              setup_q;
  logic              cap_q;
  logic              any_reset;
  logic [CW-1:0]     limit;
  logic              space;
  logic              can_write;
  logic              can_read;
  logic              can_rt;
  logic              do_write;
  logic              do_read;
  logic              do_rt;

  // ***********************************************************
  // Guards
  // ***********************************************************
  assign any_reset = user_busy_q || !prs_n_q;
  assign limit     = (wide_q ? CW'(BASE) : CW'(2 * BASE))
                   + (first_word_fall_through_q ? CW'(FIRST_WORD_FALL_THROUGH_EXTRA) : CW'(0)) - CW'(SETUP_MARGIN);
  assign space     = first_word_fall_through_q ? !lnk.input_space_available_n : lnk.full_indicator_n;
  assign can_write = !any_reset && space
                   && !(setup_q && wr_cnt_q >= limit);    // see R3, R9
  assign can_read  = !any_reset
                   && (first_word_fall_through_q ? !lnk.out_word_valid_n : lnk.empty_indicator_n);
  assign can_rt    = !any_reset && (wr_cnt_q >= CW'(MIN_XFER))          // see R10
                   && (first_word_fall_through_q || rd_cnt_q >= CW'(MIN_XFER));            // see R6
  assign do_write  = user_write && can_write;
  assign do_read   = user_read && can_read && !user_retransmit;
  assign do_rt     = user_retransmit && can_rt;

  // ***********************************************************
  // Reset sequencing and mode pins
  // ***********************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mrs_cnt_q   <= RW'(RST_C);
      mrs_n_q     <= 1'b0;
      user_busy_q <= 1'b1;
      first_word_fall_through_q      <= 1'b0;
      wide_q      <= 1'b1;
    end else if (user_master_reset && !user_busy_q) begin
      mrs_cnt_q   <= RW'(RST_C);
      mrs_n_q     <= 1'b0;
      user_busy_q <= 1'b1;
      first_word_fall_through_q      <= user_first_word_fall_through;
      wide_q      <= user_wide;
    end else if (mrs_cnt_q != '0) begin
      mrs_cnt_q <= mrs_cnt_q - RW'(1);
    end else begin
      mrs_n_q     <= 1'b1;
      user_busy_q <= !mrs_n_q;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prs_n_q <= 1'b1;
      oe_n_q  <= 1'b1;
    end else begin
      prs_n_q <= !(user_partial_reset && !user_busy_q);
      // Outputs are wanted whenever the FIFO may be read
      oe_n_q  <= !mrs_n_q;                                // see R2
    end
  end

  // ***********************************************************
  // Request strobes
  // ***********************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_en_q        <= 1'b0;
      wr_data_q      <= '0;
      rd_en_q        <= 1'b0;
      rt_q           <= 1'b0;
      user_refused_q <= 1'b0;
    end else begin
      wr_en_q        <= do_write;
      rd_en_q        <= do_read;
      rt_q           <= do_rt;
      user_refused_q <= (user_write && !can_write) || (user_retransmit && !can_rt)
                      || (user_read && !user_retransmit && !can_read);
      if (do_write) begin
        wr_data_q <= user_wdata;
      end
    end
  end

  // ***********************************************************
  // Setup window accounting
  // ***********************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_cnt_q <= '0;
      rd_cnt_q <= '0;
      setup_q  <= 1'b1;
    end else if (any_reset) begin
      wr_cnt_q <= '0;
      rd_cnt_q <= '0;
      setup_q  <= 1'b1;
    end else begin
      if (do_write && wr_cnt_q != '1) begin
        wr_cnt_q <= wr_cnt_q + CW'(1);
      end
      if (do_read && rd_cnt_q != CW'(MIN_XFER)) begin
        rd_cnt_q <= rd_cnt_q + CW'(1);
      end
      if (do_rt) begin
        setup_q <= 1'b0;
      end
    end
  end

  // ***********************************************************
  // Read data capture
  // ***********************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cap_q         <= 1'b0;
      user_rdata_q  <= '0;
      user_rvalid_q <= 1'b0;
    end else begin
      // Standard mode data lands one cycle after the strobe is taken
      cap_q <= !first_word_fall_through_q && ((rd_en_q && lnk.empty_indicator_n) || rt_q);
      if (first_word_fall_through_q && rd_en_q && !lnk.out_word_valid_n) begin
        user_rdata_q  <= lnk.read_data_bus;
        user_rvalid_q <= 1'b1;
      end else if (cap_q) begin
        user_rdata_q  <= lnk.read_data_bus;
        user_rvalid_q <= 1'b1;
      end else begin
        user_rvalid_q <= 1'b0;
      end
    end
  end

  assign lnk.master_reset_n          = mrs_n_q;
  assign lnk.partial_reset_n         = prs_n_q;
  assign lnk.retransmit_style_select = 1'b0;              // see R7
  assign lnk.first_word_fall_through = first_word_fall_through_q;
  assign lnk.wide_port               = wide_q;
  assign lnk.wr_en                   = wr_en_q;
  assign lnk.wr_data                 = wr_data_q;
  assign lnk.rd_en                   = rd_en_q;
  assign lnk.output_enable_n         = oe_n_q;
  assign lnk.retransmit_request      = rt_q;

endmodule

// ---- tb/fzr_assertions.sv ----
`timescale 1ns/1ps
module fzr_assertions import fzr_pkg::*; #(
  parameter int BASE = BASE_DEPTH
) (
  input logic              clk,
  input logic              rst,
  input logic              master_reset_n,
  input logic              partial_reset_n,
  input logic              retransmit_style_select,
  input logic              first_word_fall_through,
  input logic              wide_port,
  input logic              wr_en,
  input logic [DATA_W-1:0] wr_data,
  input logic              rd_en,
  input logic              output_enable_n,
  input logic              retransmit_request,
  input logic              full_indicator_n,
  input logic              input_space_available_n,
  input logic              empty_indicator_n,
  input logic              out_word_valid_n,
  input logic [DATA_W-1:0] read_data_out,
  input logic              read_data_oe
);
  // ***********************************************************
  // Counts since the last reset
  // ***********************************************************
  logic [15:0]       wcnt_q;
  logic [15:0]       rcnt_q;
  logic [DATA_W-1:0] w1_q;
  logic [15:0]       depth_c;

  assign depth_c = 16'((wide_port ? BASE : 2 * BASE) + (first_word_fall_through ? 1 : 0));

  // Writes since reset bound the occupancy, even after a rewind
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wcnt_q <= 16'h0000;
      rcnt_q <= 16'h0000;
    end else if (!master_reset_n || !partial_reset_n) begin
      wcnt_q <= 16'h0000;
      rcnt_q <= 16'h0000;
    end else begin
      wcnt_q <= wcnt_q + {15'h0000, wr_en};
      rcnt_q <= rcnt_q + {15'h0000, rd_en};
    end
  end

  always_ff @(posedge clk) begin
    if (wr_en && wcnt_q == 16'h0000) begin
      w1_q <= wr_data;
    end
  end

  // ***********************************************************
  // Checks
  // ***********************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_oe_drive: assert property (master_reset_n && !output_enable_n |=> read_data_oe)
    else $error("read data not driven after output enable");
  chk_oe_float: assert property (output_enable_n |=> !read_data_oe)
    else $error("read data driven without output enable");
  chk_rt_word: assert property (
    retransmit_request && !rd_en && wcnt_q >= 16'h0002 |=> read_data_out == w1_q)
    else $error("retransmit did not show the first word");
  chk_rt_std_flag: assert property (
    !first_word_fall_through && retransmit_request && wcnt_q >= 16'h0002 |=> empty_indicator_n)
    else $error("empty indicator not updated on retransmit");
  chk_rt_first_word_fall_through_flag: assert property (
    first_word_fall_through && retransmit_request && !rd_en && wcnt_q >= 16'h0002
    |=> !out_word_valid_n)
    else $error("output word valid not updated on retransmit");
  chk_full_setup: assert property (
    !first_word_fall_through && wcnt_q + 16'h0002 <= depth_c |-> full_indicator_n)
    else $error("full indicator low during setup");
  chk_space_setup: assert property (
    first_word_fall_through && wcnt_q + 16'h0002 <= depth_c |-> !input_space_available_n)
    else $error("input space lost during setup");
  chk_style_low: assert property (!master_reset_n |-> !retransmit_style_select)
    else $error("retransmit style high in master reset");
  chk_rt_setup: assert property (retransmit_request |-> wcnt_q >= 16'h0002 &&
    (first_word_fall_through || rcnt_q >= 16'h0002))
    else $error("retransmit before enough transfers");

  cov_rt_std: cover property (retransmit_request && !first_word_fall_through);
  cov_rt_first_word_fall_through: cover property (retransmit_request && first_word_fall_through);
  cov_narrow: cover property (!wide_port && wr_en && wcnt_q == 16'h0005);
endmodule

// ---- tb/fifo_zero_latency_retransmit_tb.sv ----
`timescale 1ns/1ps
module fifo_zero_latency_retransmit_tb import fzr_pkg::*; ();
  // ***********************************************************
  // Bench signals
  // ***********************************************************
  localparam int BASE = 4;
  logic              clk;
  logic              rst;
  logic              mr;
  logic              pr;
  logic              fw;
  logic              wd;
  logic              wr;
  logic              rd;
  logic              rt;
  logic [DATA_W-1:0] wdat;
  logic [DATA_W-1:0] rdata;
  logic              rvalid;
  logic              refused;
  logic              busy;
  logic [$clog2(2*BASE):0] level;
  int                num_errors = 0;
  int                cmp_count = 0;
  int                cyc = 0;

  fzr_if lnk ();

  fzr_device #(.BASE(BASE)) fzr_device_inst (
    .clk(clk), .rst(rst), .lnk(lnk), .level_q(level)
  );

  // Short reset count keeps the run small
  fzr_host #(.BASE(BASE), .RST_C(1)) fzr_host_inst (
    .clk(clk), .rst(rst), .lnk(lnk),
    .user_master_reset(mr), .user_partial_reset(pr),
    .user_first_word_fall_through(fw), .user_wide(wd), .user_write(wr), .user_wdata(wdat),
    .user_read(rd), .user_retransmit(rt), .user_rdata_q(rdata),
    .user_rvalid_q(rvalid), .user_refused_q(refused), .user_busy_q(busy)
  );

  fzr_assertions #(.BASE(BASE)) fzr_assertions_inst (
    .clk(clk), .rst(rst),
    .master_reset_n(lnk.master_reset_n), .partial_reset_n(lnk.partial_reset_n),
    .retransmit_style_select(lnk.retransmit_style_select),
    .first_word_fall_through(lnk.first_word_fall_through),
    .wide_port(lnk.wide_port), .wr_en(lnk.wr_en), .wr_data(lnk.wr_data),
    .rd_en(lnk.rd_en), .output_enable_n(lnk.output_enable_n),
    .retransmit_request(lnk.retransmit_request),
    .full_indicator_n(lnk.full_indicator_n),
    .input_space_available_n(lnk.input_space_available_n),
    .empty_indicator_n(lnk.empty_indicator_n),
    .out_word_valid_n(lnk.out_word_valid_n),
    .read_data_out(lnk.read_data_out), .read_data_oe(lnk.read_data_oe)
  );

  // ***********************************************************
  // Clock, timeout and shared tasks
  // ***********************************************************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      results();
    end
  end

  task automatic results();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic cmp(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmpb(input logic got, input logic exp);
    cmp({17'h00000, got}, {17'h00000, exp});
  endtask

  task automatic idle();
    int n;
    n = 0;
    repeat (3) @(posedge clk);
    #1;
    while (busy !== 1'b0 && n < 60) begin
      @(posedge clk);
      #1 n++;
    end
    cmpb(busy, 1'b0);
  endtask

  // Kind 0 writes, 1 reads, 2 retransmits; refusal shows one cycle later
  task automatic req(input int k, input logic [DATA_W-1:0] d, input logic exp_ref);
    @(posedge clk);
    wr <= (k == 0);
    rd <= (k == 1);
    rt <= (k == 2);
    wdat <= d;
    @(posedge clk);
    {wr, rd, rt} <= 3'h0;
    #1 cmpb(refused, exp_ref);
  endtask

  task automatic get(input int k, input logic [DATA_W-1:0] exp);
    int n;
    n = 0;
    req(k, 18'h00000, 1'b0);
    while (rvalid !== 1'b1 && n < 8) begin
      @(posedge clk);
      #1 n++;
    end
    cmpb(rvalid, 1'b1);
    cmp(rdata, exp);
  endtask

  task automatic rst_cmd(input logic p, input logic f, input logic w);
    @(posedge clk);
    fw <= f;
    wd <= w;
    if (p) pr <= 1'b1;
    else mr <= 1'b1;
    @(posedge clk);
    {mr, pr} <= 2'h0;
    idle();
  endtask

  // ***********************************************************
  // Scenarios
  // ***********************************************************
  task automatic std_wide();
    rst_cmd(1'b0, 1'b0, 1'b1);
    req(0, 18'h0A5A1, 1'b0);
    req(0, 18'h0A5A2, 1'b0);
    req(0, 18'h0A5A3, 1'b1);
    req(2, 18'h00000, 1'b1);
    get(1, 18'h0A5A1);
    get(1, 18'h0A5A2);
    cmp(lnk.read_data_bus, 18'h0A5A2);
    cmpb(lnk.empty_indicator_n, 1'b0);
    get(2, 18'h0A5A1);
    cmpb(lnk.empty_indicator_n, 1'b1);
    cmp(18'(level), 18'h00001);
    get(1, 18'h0A5A2);
  endtask

  task automatic std_narrow();
    rst_cmd(1'b0, 1'b0, 1'b0);
    for (int i = 0; i < 2 * BASE - 2; i++) begin
      req(0, 18'h1C000 | 18'(i), 1'b0);
    end
    req(0, 18'h1C0FF, 1'b1);
    cmpb(lnk.full_indicator_n, 1'b1);
    cmp(18'(level), 18'h00006);
  endtask

  task automatic first_word_fall_through_wide();
    rst_cmd(1'b0, 1'b1, 1'b1);
    req(0, 18'h2B001, 1'b0);
    req(2, 18'h00000, 1'b1);
    req(0, 18'h2B002, 1'b0);
    req(0, 18'h2B003, 1'b0);
    req(0, 18'h2B004, 1'b1);
    cmpb(lnk.input_space_available_n, 1'b0);
    cmp(18'(level), 18'h00003);
    get(1, 18'h2B001);
    get(1, 18'h2B002);
    get(1, 18'h2B003);
    repeat (2) @(posedge clk);
    #1 cmpb(lnk.out_word_valid_n, 1'b1);
    req(2, 18'h00000, 1'b0);
    repeat (2) @(posedge clk);
    #1 cmpb(lnk.out_word_valid_n, 1'b0);
    cmp(lnk.read_data_bus, 18'h2B001);
    cmp(18'(level), 18'h00003);
  endtask

  // Replay after a partial reset starts from the first word stored since it
  task automatic part_reset();
    rst_cmd(1'b1, 1'b1, 1'b1);
    cmpb(lnk.out_word_valid_n, 1'b1);
    req(0, 18'h3D001, 1'b0);
    req(0, 18'h3D002, 1'b0);
    req(2, 18'h00000, 1'b0);
    repeat (2) @(posedge clk);
    #1 cmp(lnk.read_data_bus, 18'h3D001);
  endtask

  initial begin
    rst = 1'b1;
    {mr, pr, fw, wd, wr, rd, rt} = 7'h00;
    wdat = 18'h00000;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    idle();
    std_wide();
    std_narrow();
    first_word_fall_through_wide();
    part_reset();
    results();
  end
endmodule
